// [asb_core.sv]
// arithmetic shift and conditional branch execute unit with apb registers
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module asb_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    case (sz)
      asb_pkg::SIZE_BYTE: size_mask = asb_pkg::BYTE_MASK;
      asb_pkg::SIZE_LONG: size_mask = asb_pkg::LONG_MASK;
      default: size_mask = asb_pkg::WORD_MASK;
    endcase
  endfunction

  function automatic logic [31:0] top_bit(input logic [1:0] sz);
    top_bit = size_mask(sz) & ~(size_mask(sz) >> 1);
  endfunction

  function automatic logic ea_alterable(input logic [2:0] mode, input logic [2:0] rg);
    ea_alterable = (mode >= asb_pkg::MODE_IND && mode <= asb_pkg::MODE_INDEXED) ||
      (mode == asb_pkg::MODE_OTHER &&
       (rg == asb_pkg::EAREG_ABS_SHORT || rg == asb_pkg::EAREG_ABS_LONG));
  endfunction

  function automatic logic cond_test(input logic [3:0] cc, input asb_pkg::asb_flags_t f);
    case (cc)
      asb_pkg::CC_HI: cond_test = !f.c && !f.z;
      asb_pkg::CC_LS: cond_test = f.c || f.z;
      asb_pkg::CC_CC: cond_test = !f.c;
      asb_pkg::CC_CS: cond_test = f.c;
      asb_pkg::CC_NE: cond_test = !f.z;
      asb_pkg::CC_EQ: cond_test = f.z;
      asb_pkg::CC_VC: cond_test = !f.v;
      asb_pkg::CC_VS: cond_test = f.v;
      asb_pkg::CC_PL: cond_test = !f.n;
      asb_pkg::CC_MI: cond_test = f.n;
      asb_pkg::CC_GE: cond_test = f.n == f.v;
      asb_pkg::CC_LT: cond_test = f.n != f.v;
      asb_pkg::CC_GT: cond_test = !f.z && (f.n == f.v);
      asb_pkg::CC_LE: cond_test = f.z || (f.n != f.v);
      default: cond_test = 1'b0;
    endcase
  endfunction

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FINISH} asb_state_t;

  // ****************************************
  // storage
  // ****************************************
  asb_state_t state;
  logic [15:0] opcode;
  logic [31:0] ext;
  logic [31:0] pc;
  logic [31:0] operand;
  logic [31:0] count_src;
  logic [31:0] result;
  asb_pkg::asb_flags_t flags;
  asb_pkg::asb_status_t status;
  logic [31:0] work;
  logic [6:0] steps;
  logic [1:0] size;
  logic dir_left;
  logic count_zero;
  logic last_out;
  logic v_acc;

  // ****************************************
  // bus decode
  // ****************************************
  logic bus_write;
  logic reg_wr;
  logic op_write;
  logic mapped;
  assign bus_write = psel && penable && pwrite && pready;
  // register writes are dropped while a shift runs
  assign reg_wr = bus_write && !status.busy;
  assign op_write = reg_wr && (paddr == asb_pkg::ADDR_OPCODE);
  always_comb begin
    case (paddr)
      asb_pkg::ADDR_OPCODE, asb_pkg::ADDR_EXT, asb_pkg::ADDR_PC, asb_pkg::ADDR_OPERAND,
      asb_pkg::ADDR_COUNT, asb_pkg::ADDR_CCR, asb_pkg::ADDR_RESULT,
      asb_pkg::ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************
  // instruction decode of the written opcode
  // ****************************************
  logic [15:0] new_op;
  logic is_shift;
  logic is_branch;
  logic mem_form;
  logic [1:0] new_size;
  logic ea_ok;
  logic shift_ok;
  logic [6:0] new_count;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [2:0] cnt_field;
  logic [7:0] disp8;
  logic [1:0] ext_words;
  logic [31:0] disp;
  logic [31:0] next_pc;
  logic branch_true;
  always_comb begin
    new_op = pwdata[15:0];
    is_shift = new_op[asb_pkg::OP_CLASS_LSB +: 4] == asb_pkg::CLASS_SHIFT;
    is_branch = new_op[asb_pkg::OP_CLASS_LSB +: 4] == asb_pkg::CLASS_BRANCH;
    mem_form = new_op[asb_pkg::OP_SIZE_LSB +: 2] == asb_pkg::SIZE_MEM;
    new_size = mem_form ? asb_pkg::SIZE_WORD : new_op[asb_pkg::OP_SIZE_LSB +: 2];
    ea_mode = new_op[asb_pkg::OP_EA_MODE_LSB +: 3];
    ea_reg = new_op[asb_pkg::OP_EA_REG_LSB +: 3];
    cnt_field = new_op[asb_pkg::OP_COUNT_LSB +: 3];
    ea_ok = ea_alterable(ea_mode, ea_reg);
    if (mem_form) begin
      shift_ok = is_shift && cnt_field == asb_pkg::MEM_ARITH_FIELD && ea_ok;
    end else begin
      shift_ok = is_shift && new_op[asb_pkg::OP_TYPE_LSB +: 2] == asb_pkg::TYPE_ARITH;
    end
    if (mem_form) begin
      new_count = asb_pkg::MEM_COUNT;
    end else if (new_op[asb_pkg::OP_IR_BIT]) begin
      new_count = count_src[6:0] & asb_pkg::COUNT_MOD_MASK;
    end else if (cnt_field == asb_pkg::IMM_ZERO_FIELD) begin
      new_count = asb_pkg::IMM_ZERO_COUNT;
    end else begin
      new_count = {4'h0, cnt_field};
    end
    disp8 = new_op[asb_pkg::OP_DISP_LSB +: 8];
    if (disp8 == asb_pkg::DISP_USE_WORD) begin
      ext_words = asb_pkg::EXT_ONE;
      disp = {{16{ext[31]}}, ext[asb_pkg::EXT_WORD_LSB +: 16]};
    end else if (disp8 == asb_pkg::DISP_USE_LONG) begin
      ext_words = asb_pkg::EXT_TWO;
      disp = ext;
    end else begin
      ext_words = asb_pkg::EXT_NONE;
      disp = {{24{disp8[7]}}, disp8};
    end
    branch_true = cond_test(new_op[asb_pkg::OP_COND_LSB +: 4], flags);
    if (branch_true) begin
      next_pc = pc + asb_pkg::OPWORD_BYTES + disp;
    end else begin
      next_pc = pc + asb_pkg::OPWORD_BYTES + (asb_pkg::OPWORD_BYTES * {30'h0, ext_words});
    end
  end

  // ****************************************
  // one shift step
  // ****************************************
  logic [31:0] next_work;
  logic step_out;
  logic step_v;
  always_comb begin
    if (dir_left) begin
      next_work = (work << 1) & size_mask(size);
      step_out = |(work & top_bit(size));
    end else begin
      next_work = (work >> 1) | (work & top_bit(size));
      step_out = work[0];
    end
    step_v = |((work ^ next_work) & top_bit(size));
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      work <= '0;
      steps <= '0;
      size <= asb_pkg::SIZE_BYTE;
      dir_left <= 1'b0;
      count_zero <= 1'b0;
      last_out <= 1'b0;
      v_acc <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (op_write && shift_ok) begin
            dir_left <= new_op[asb_pkg::OP_DIR_BIT];
            size <= new_size;
            work <= operand & size_mask(new_size);
            steps <= new_count;
            count_zero <= new_count == '0;
            last_out <= 1'b0;
            v_acc <= 1'b0;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (steps != '0) begin
            work <= next_work;
            last_out <= step_out;
            v_acc <= v_acc | step_v;
            steps <= steps - 7'h01;
          end else begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // software and execution state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode <= '0;
      ext <= '0;
      operand <= '0;
      count_src <= '0;
    end else if (reg_wr) begin
      case (paddr)
        asb_pkg::ADDR_OPCODE: opcode <= pwdata[15:0];
        asb_pkg::ADDR_EXT: ext <= pwdata;
        asb_pkg::ADDR_OPERAND: operand <= pwdata;
        asb_pkg::ADDR_COUNT: count_src <= pwdata;
        default: opcode <= opcode;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= '0;
    end else if (op_write && is_branch) begin
      pc <= next_pc;
    end else if (reg_wr && paddr == asb_pkg::ADDR_PC) begin
      pc <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (state == ST_FINISH) begin
      result <= (operand & ~size_mask(size)) | work;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= asb_pkg::FLAGS_RESET;
    end else if (state == ST_FINISH) begin
      flags.x <= count_zero ? flags.x : last_out;
      flags.c <= count_zero ? 1'b0 : last_out;
      flags.n <= |(work & top_bit(size));
      flags.z <= work == '0;
      flags.v <= v_acc;
    end else if (reg_wr && paddr == asb_pkg::ADDR_CCR) begin
      flags <= asb_pkg::asb_flags_t'(pwdata[4:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= asb_pkg::STATUS_RESET;
    end else if (op_write) begin
      status.busy <= shift_ok;
      status.done <= !shift_ok;
      status.illegal <= !shift_ok && !is_branch;
      status.taken <= is_branch && branch_true;
      status.ea_reject <= is_shift && mem_form && !ea_ok;
      status.ext_words <= is_branch ? ext_words : asb_pkg::EXT_NONE;
    end else if (state == ST_FINISH) begin
      status.busy <= 1'b0;
      status.done <= 1'b1;
    end
  end

  // ****************************************
  // apb answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          asb_pkg::ADDR_OPCODE: prdata <= {16'h0000, opcode};
          asb_pkg::ADDR_EXT: prdata <= ext;
          asb_pkg::ADDR_PC: prdata <= pc;
          asb_pkg::ADDR_OPERAND: prdata <= operand;
          asb_pkg::ADDR_COUNT: prdata <= count_src;
          asb_pkg::ADDR_CCR: prdata <= {27'h0000000, flags};
          asb_pkg::ADDR_RESULT: prdata <= result;
          asb_pkg::ADDR_STATUS: prdata <= {25'h0000000, status};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule // asb_core

// [asb_pkg.sv]
// constants, field positions and carrier types for the shift and branch unit
package asb_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_OPCODE = 8'h00;
  localparam logic [7:0] ADDR_EXT = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_OPERAND = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CCR = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // ****************************************
  // opcode field positions
  // ****************************************
  localparam int OP_CLASS_LSB = 12;
  localparam int OP_COUNT_LSB = 9;
  localparam int OP_COND_LSB = 8;
  localparam int OP_DIR_BIT = 8;
  localparam int OP_SIZE_LSB = 6;
  localparam int OP_IR_BIT = 5;
  localparam int OP_TYPE_LSB = 3;
  localparam int OP_EA_MODE_LSB = 3;
  localparam int OP_EA_REG_LSB = 0;
  localparam int OP_DISP_LSB = 0;
  localparam int EXT_WORD_LSB = 16;
  // ****************************************
  // opcode encodings
  // ****************************************
  localparam logic [3:0] CLASS_SHIFT = 4'hE;
  localparam logic [3:0] CLASS_BRANCH = 4'h6;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_MEM = 2'h3;
  localparam logic [1:0] TYPE_ARITH = 2'h0;
  localparam logic [2:0] MEM_ARITH_FIELD = 3'h0;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_INDEXED = 3'h6;
  localparam logic [2:0] MODE_OTHER = 3'h7;
  localparam logic [2:0] EAREG_ABS_SHORT = 3'h0;
  localparam logic [2:0] EAREG_ABS_LONG = 3'h1;
  localparam logic [2:0] IMM_ZERO_FIELD = 3'h0;
  localparam logic [6:0] IMM_ZERO_COUNT = 7'h08;
  localparam logic [6:0] MEM_COUNT = 7'h01;
  localparam logic [7:0] DISP_USE_WORD = 8'h00;
  localparam logic [7:0] DISP_USE_LONG = 8'hFF;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_ONE = 2'h1;
  localparam logic [1:0] EXT_TWO = 2'h2;
  localparam logic [6:0] COUNT_MOD_MASK = 7'h3F;
  localparam logic [31:0] OPWORD_BYTES = 32'h00000002;
  localparam logic [31:0] LONG_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] WORD_MASK = 32'h0000FFFF;
  localparam logic [31:0] BYTE_MASK = 32'h000000FF;
  // ****************************************
  // condition tests
  // ****************************************
  localparam logic [3:0] CC_HI = 4'h2;
  localparam logic [3:0] CC_LS = 4'h3;
  localparam logic [3:0] CC_CC = 4'h4;
  localparam logic [3:0] CC_CS = 4'h5;
  localparam logic [3:0] CC_NE = 4'h6;
  localparam logic [3:0] CC_EQ = 4'h7;
  localparam logic [3:0] CC_VC = 4'h8;
  localparam logic [3:0] CC_VS = 4'h9;
  localparam logic [3:0] CC_PL = 4'hA;
  localparam logic [3:0] CC_MI = 4'hB;
  localparam logic [3:0] CC_GE = 4'hC;
  localparam logic [3:0] CC_LT = 4'hD;
  localparam logic [3:0] CC_GT = 4'hE;
  localparam logic [3:0] CC_LE = 4'hF;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } asb_flags_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic illegal;
    logic taken;
    logic ea_reject;
    logic [1:0] ext_words;
  } asb_status_t;
  localparam asb_flags_t FLAGS_RESET = '0;
  localparam asb_status_t STATUS_RESET = '0;
endpackage

// [asb_core_assertions.sv]
// bus port checker for the shift and branch unit
`timescale 1ns/1ps
module asb_core_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // *****
  // bus checks
  // *****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd;
  logic bad;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign bad = (paddr[1:0] != 2'h0) || (paddr > 8'h1C);
  chk_ready_up: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  chk_err_phase: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  chk_err_unmap: assert property (acc && bad |-> pslverr)
    else $error("no pslverr on unmapped address");
  chk_err_mapped: assert property (acc && !bad |-> !pslverr)
    else $error("pslverr on mapped address");
  chk_rd_unmap: assert property (rd && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (rd |=> $stable(prdata))
    else $error("read data moved after access");
  chk_ext_count: assert property (rd && paddr == 8'h1C |-> prdata[1:0] != 2'h3)
    else $error("extension count out of range");
  chk_stat_bits: assert property (rd && paddr == 8'h1C |-> prdata[31:7] == 25'h0)
    else $error("status spare bits set");
  chk_flag_bits: assert property (rd && paddr == 8'h14 |-> prdata[31:5] == 27'h0)
    else $error("flag spare bits set");
endmodule // asb_core_assertions
bind asb_core asb_core_assertions i_asb_core_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// [tb_top.sv]
// self-checking bench for the shift and branch unit
`timescale 1ns/1ps
module tb_top;
  // *****
  // signals and rows
  // *****
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] a;
    logic [31:0] b;
    logic [4:0] f;
  } asb_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] q;
  logic err;
  int mismatches = 0;
  int n_tests = 0;
  event hang;
  logic [15:0] bad_ea [5] = '{16'hE0C0, 16'hE1C8, 16'hE0FC, 16'hE1FA, 16'hE0FB};
  asb_row_t rows [21] = '{
    '{16'hE000, 32'h12345680, 32'h0, 5'h00},
    '{16'hE740, 32'h00006001, 32'h0, 5'h00},
    '{16'hE280, 32'h80000001, 32'h0, 5'h10},
    '{16'hE3A0, 32'h00000003, 32'h47, 5'h00},
    '{16'hE120, 32'h000000FF, 32'h40, 5'h11},
    '{16'hEF00, 32'h000000C1, 32'h0, 5'h00},
    '{16'hE460, 32'h00008000, 32'h3F, 5'h00},
    '{16'hE1D0, 32'h1234C000, 32'h0, 5'h00},
    '{16'hE0D8, 32'h00008001, 32'h0, 5'h00},
    '{16'hE1E0, 32'h00004000, 32'h0, 5'h00},
    '{16'hE0E8, 32'h00000001, 32'h0, 5'h10},
    '{16'hE1F0, 32'hFFFF0000, 32'h0, 5'h00},
    '{16'hE0F8, 32'h00007FFE, 32'h0, 5'h00},
    '{16'hE1F9, 32'h00008000, 32'h0, 5'h00},
    '{16'h6710, 32'h0, 32'h1000, 5'h04},
    '{16'h6680, 32'h0, 32'h1000, 5'h00},
    '{16'h6400, 32'hFFF00000, 32'h2000, 5'h00},
    '{16'h6500, 32'h00020000, 32'h3000, 5'h01},
    '{16'h6DFF, 32'h00012340, 32'h4000, 5'h08},
    '{16'h6DFF, 32'h00012340, 32'h4000, 5'h0A},
    '{16'h6C00, 32'h00080000, 32'h5000, 5'h08}
  };
  always #50 pclk = ~pclk;
  asb_core i_asb_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // *****
  // tasks and models
  // *****
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      mismatches++;
      -> hang;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    do begin
      xfer(1'b0, asb_pkg::ADDR_STATUS, 32'h0);
      i++;
    end while (q[6] !== 1'b0 && i < 200);
    if (i >= 200) begin
      mismatches++;
      -> hang;
    end
  endtask
  task automatic load(input asb_row_t r);
    xfer(1'b1, asb_pkg::ADDR_OPERAND, r.a);
    xfer(1'b1, asb_pkg::ADDR_EXT, r.a);
    xfer(1'b1, asb_pkg::ADDR_COUNT, r.b);
    xfer(1'b1, asb_pkg::ADDR_PC, r.b);
    xfer(1'b1, asb_pkg::ADDR_CCR, {27'h0, r.f});
    xfer(1'b1, asb_pkg::ADDR_OPCODE, {16'h0, r.op});
  endtask
  function automatic logic [36:0] shift_model(input asb_row_t r);
    int w;
    int n;
    logic [31:0] m;
    logic [31:0] u;
    logic x;
    logic c;
    logic v;
    logic t;
    w = r.op[7:6] == 2'h0 ? 8 : r.op[7:6] == 2'h2 ? 32 : 16;
    if (r.op[7:6] == 2'h3) n = 1;
    else if (r.op[5]) n = int'(r.b[5:0]);
    else n = r.op[11:9] == 3'h0 ? 8 : int'(r.op[11:9]);
    m = w == 32 ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
    u = r.a & m;
    x = r.f[4];
    c = 1'b0;
    v = 1'b0;
    for (int k = 0; k < n; k++) begin
      t = u[w-1];
      c = r.op[8] ? t : u[0];
      u = r.op[8] ? (u << 1) & m : u >> 1;
      if (!r.op[8]) u[w-1] = t;
      v = v | (u[w-1] != t);
      x = c;
    end
    return {(r.a & ~m) | u, x, u[w-1], u == 32'h0, v, c};
  endfunction
  function automatic logic [31:0] pc_model(input asb_row_t r, output logic tk,
                                           output logic [1:0] nw);
    logic [31:0] d;
    logic n;
    logic z;
    logic v;
    logic c;
    {n, z, v, c} = r.f[3:0];
    nw = r.op[7:0] == 8'h00 ? 2'h1 : r.op[7:0] == 8'hFF ? 2'h2 : 2'h0;
    d = {{24{r.op[7]}}, r.op[7:0]};
    if (nw == 2'h1) d = {{16{r.a[31]}}, r.a[31:16]};
    if (nw == 2'h2) d = r.a;
    case (r.op[11:8])
      asb_pkg::CC_HI: tk = !c && !z;
      asb_pkg::CC_LS: tk = c || z;
      asb_pkg::CC_CC: tk = !c;
      asb_pkg::CC_CS: tk = c;
      asb_pkg::CC_NE: tk = !z;
      asb_pkg::CC_EQ: tk = z;
      asb_pkg::CC_VC: tk = !v;
      asb_pkg::CC_VS: tk = v;
      asb_pkg::CC_PL: tk = !n;
      asb_pkg::CC_MI: tk = n;
      asb_pkg::CC_GE: tk = n == v;
      asb_pkg::CC_LT: tk = n != v;
      asb_pkg::CC_GT: tk = !z && n == v;
      asb_pkg::CC_LE: tk = z || n != v;
      default: tk = 1'b0;
    endcase
    return r.b + 32'h2 + (tk ? d : {29'h0, nw, 1'b0});
  endfunction
  task automatic run(input asb_row_t r);
    logic [36:0] e;
    logic [31:0] p;
    logic tk;
    logic [1:0] nw;
    load(r);
    wait_idle();
    if (r.op[15:12] == asb_pkg::CLASS_SHIFT) begin
      e = shift_model(r);
      check("shift status", q, 32'h20);
      xfer(1'b0, asb_pkg::ADDR_RESULT, 32'h0);
      check("result", q, e[36:5]);
      xfer(1'b0, asb_pkg::ADDR_CCR, 32'h0);
      check("shift flags", q, {27'h0, e[4:0]});
    end else begin
      p = pc_model(r, tk, nw);
      check("branch status", q, {26'h0, 2'h2, tk, 1'b0, nw});
      xfer(1'b0, asb_pkg::ADDR_PC, 32'h0);
      check("pc", q, p);
      xfer(1'b0, asb_pkg::ADDR_CCR, 32'h0);
      check("branch flags", q, {27'h0, r.f});
    end
  endtask
  // *****
  // sequence
  // *****
  initial begin
    @hang;
    conclude();
  end
  initial begin
    asb_row_t r;
    logic [36:0] e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    foreach (rows[i]) run(rows[i]);
    for (int i = 0; i < 256; i++) run('{{4'h6, i[7:4], 8'h04}, 32'h0, 32'h100, {1'b1, i[3:0]}});
    $display("test rows done");
    foreach (bad_ea[i]) begin
      xfer(1'b1, asb_pkg::ADDR_OPCODE, {16'h0, bad_ea[i]});
      wait_idle();
      check("reject", {29'h0, q[4:2]}, 32'h5);
    end
    xfer(1'b1, asb_pkg::ADDR_OPCODE, 32'hE008);
    wait_idle();
    check("illegal type", {29'h0, q[4:2]}, 32'h4);
    xfer(1'b1, asb_pkg::ADDR_OPCODE, 32'hE2D0);
    wait_idle();
    check("illegal count", {29'h0, q[4:2]}, 32'h4);
    $display("test address modes done");
    r = '{16'hE460, 32'h00008000, 32'h3F, 5'h00};
    e = shift_model(r);
    load(r);
    xfer(1'b1, asb_pkg::ADDR_OPERAND, 32'h0);
    xfer(1'b1, asb_pkg::ADDR_OPCODE, 32'hE740);
    wait_idle();
    xfer(1'b0, asb_pkg::ADDR_RESULT, 32'h0);
    check("busy result", q, e[36:5]);
    xfer(1'b0, asb_pkg::ADDR_OPERAND, 32'h0);
    check("busy operand", q, 32'h8000);
    $display("test busy refusal done");
    xfer(1'b1, asb_pkg::ADDR_RESULT, 32'h0);
    xfer(1'b0, asb_pkg::ADDR_RESULT, 32'h0);
    check("result read only", q, e[36:5]);
    xfer(1'b1, 8'h20, 32'h1);
    check("write error", {31'h0, err}, 32'h1);
    xfer(1'b0, 8'h22, 32'h0);
    check("read error", {31'h0, err}, 32'h1);
    check("read zero", q, 32'h0);
    $display("test bus errors done");
    load(r);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      check("reset value", q, 32'h0);
    end
    $display("test second reset done");
    conclude();
  end
endmodule // tb_top
